/* File: hdl/tws_status_map.vh */
// register offsets, field positions and reset values of the status-flag block
// assumes a byte-addressed 32-bit avalon-mm slave with a 4-bit address and word offsets 0, 4 and 8
`ifndef TWS_STATUS_MAP_VH
`define TWS_STATUS_MAP_VH

`define TWS_ADDR_W          4
`define TWS_OFF_STATUS      4'h0
`define TWS_OFF_RXHOLD      4'h4
`define TWS_OFF_TXHOLD      4'h8

`define TWS_BIT_TXFULL      0
`define TWS_BIT_RXFULL      1
`define TWS_BIT_DIR         2
`define TWS_BIT_START       3
`define TWS_BIT_STOP        4
`define TWS_BIT_OVF         6
`define TWS_BIT_WCOL        7

`define TWS_FLAG_RST        1'b0
`define TWS_WAIT_RST        1'b1
`define TWS_BYTE_RST        8'h00
`define TWS_WORD_ZERO       32'h00000000

`endif

/* File: hdl/tws_status.v */
// status flags of a two-wire serial bus module with avalon-mm register slave
// assumes bus sequencing logic on clk_i delivers one-cycle event pulses,
// so the event inputs share the clock and pass no synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "tws_status_map.vh"

module tws_status
#(
	parameter DATA_W = 8
)
(
	input  wire              clk_i,
	input  wire              rst_n_i,
	input  wire              clk_en_i,
	input  wire [3:0]        avs_address_i,
	input  wire              avs_read_i,
	input  wire              avs_write_i,
	input  wire [31:0]       avs_writedata_i,
	input  wire [3:0]        avs_byteenable_i,
	output reg  [31:0]       avs_readdata_o,
	output reg               avs_waitrequest_o,
	input  wire              start_det_i,
	input  wire              stop_det_i,
	input  wire              addr_rcvd_i,
	input  wire              addr_rw_i,
	input  wire              byte_rcvd_i,
	input  wire [DATA_W-1:0] rx_byte_i,
	input  wire              tx_done_i,
	input  wire              busy_i,
	output reg  [DATA_W-1:0] tx_byte_o,
	output reg               tx_load_o
);

	reg              stop_seen;
	reg              start_seen;
	reg              direction;
	reg              receive_full;
	reg              transmit_full;
	reg              receive_overflow;
	reg              write_collision;
	reg [DATA_W-1:0] rx_hold;
	reg              ack_done;

	// a request is taken once; ack_done masks the cycle in which it is answered
	wire acc      = (avs_read_i | avs_write_i) & ~ack_done;
	wire rd_rx    = acc & avs_read_i & (avs_address_i == `TWS_OFF_RXHOLD);
	wire wr_stat  = acc & avs_write_i & (avs_address_i == `TWS_OFF_STATUS)
	                & avs_byteenable_i[0];
	wire wr_tx    = acc & avs_write_i & (avs_address_i == `TWS_OFF_TXHOLD)
	                & avs_byteenable_i[0];
	wire tx_block = busy_i | transmit_full;
	wire [7:0] clr = avs_writedata_i[7:0];

	// software clear strobes; only the two sticky error flags are writable
	wire clr_ovf  = wr_stat & clr[`TWS_BIT_OVF];
	wire clr_wcol = wr_stat & clr[`TWS_BIT_WCOL];

	// receive path: load when empty, or when software drains it in the same cycle
	wire rx_load  = byte_rcvd_i & (~receive_full | rd_rx);
	// a byte that finds the holding register still full is lost
	wire rx_lost  = byte_rcvd_i & receive_full & ~rd_rx;

	// transmit path: accept only when the module is idle and the register empty
	wire tx_take  = wr_tx & ~tx_block;
	// a write that finds the module busy is dropped and reported
	wire tx_coll  = wr_tx & tx_block;

	reg  [31:0] stat_word;
	reg  [31:0] next_rdata;

	// status word built at the mapped field positions,
	// every bit not listed here reads zero
	always @*
	begin
		stat_word                  = `TWS_WORD_ZERO;
		stat_word[`TWS_BIT_TXFULL] = transmit_full;
		stat_word[`TWS_BIT_RXFULL] = receive_full;
		stat_word[`TWS_BIT_DIR]    = direction;
		stat_word[`TWS_BIT_START]  = start_seen;
		stat_word[`TWS_BIT_STOP]   = stop_seen;
		stat_word[`TWS_BIT_OVF]    = receive_overflow;
		stat_word[`TWS_BIT_WCOL]   = write_collision;
	end

	// read data mux; unmapped offsets and the transmit register read zero,
	// readdata is registered, so a read shows flags as of the taking edge
	always @*
	begin
		next_rdata = `TWS_WORD_ZERO;
		case (avs_address_i)
			`TWS_OFF_STATUS: next_rdata = stat_word;
			`TWS_OFF_RXHOLD: next_rdata[DATA_W-1:0] = rx_hold;
			default:         next_rdata = `TWS_WORD_ZERO;
		endcase
	end

	// bus handshake: a request is taken on the first edge it is seen,
	// waitrequest drops for one cycle after it and readdata stands with it;
	// ack_done keeps the still-held request from being taken twice
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			avs_waitrequest_o <= `TWS_WAIT_RST;
			avs_readdata_o    <= `TWS_WORD_ZERO;
			ack_done          <= `TWS_FLAG_RST;
		end
		else if (clk_en_i)
		begin
			if (acc)
			begin
				avs_waitrequest_o <= 1'b0;
				avs_readdata_o    <= next_rdata;
				ack_done          <= 1'b1;
			end
			else
			begin
				avs_waitrequest_o <= 1'b1;
				ack_done          <= 1'b0;
			end
		end
	end

	// bus condition and direction flags, hardware only;
	// stop wins when both conditions pulse in one cycle,
	// so the two condition flags are never set together;
	// direction moves only on a received address byte
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stop_seen  <= `TWS_FLAG_RST;
			start_seen <= `TWS_FLAG_RST;
			direction  <= `TWS_FLAG_RST;
		end
		else if (clk_en_i)
		begin
			if (stop_det_i)
			begin
				stop_seen  <= 1'b1;
				start_seen <= 1'b0;
			end
			else if (start_det_i)
			begin
				stop_seen  <= 1'b0;
				start_seen <= 1'b1;
			end
			if (addr_rcvd_i)
				direction <= addr_rw_i;
		end
	end

	// receive holding register, full and overflow flags;
	// the overflow set beats a software clear in the same cycle,
	// and the held byte is never overwritten while it is unread
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_hold          <= {DATA_W{1'b0}};
			receive_full     <= `TWS_FLAG_RST;
			receive_overflow <= `TWS_FLAG_RST;
		end
		else if (clk_en_i)
		begin
			if (rx_lost)
				receive_overflow <= 1'b1;
			else if (clr_ovf)
				receive_overflow <= 1'b0;
			if (rx_load)
			begin
				rx_hold      <= rx_byte_i;
				receive_full <= 1'b1;
			end
			else if (rd_rx)
				receive_full <= 1'b0;
		end
	end

	// transmit holding register, full and collision flags;
	// the collision set beats a software clear in the same cycle,
	// and tx_load_o is a one-cycle strobe to the shifter
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_byte_o       <= {DATA_W{1'b0}};
			tx_load_o       <= `TWS_FLAG_RST;
			transmit_full   <= `TWS_FLAG_RST;
			write_collision <= `TWS_FLAG_RST;
		end
		else if (clk_en_i)
		begin
			tx_load_o <= 1'b0;
			if (tx_coll)
				write_collision <= 1'b1;
			else if (clr_wcol)
				write_collision <= 1'b0;
			if (tx_take)
			begin
				tx_byte_o     <= avs_writedata_i[DATA_W-1:0];
				tx_load_o     <= 1'b1;
				transmit_full <= 1'b1;
			end
			else if (tx_done_i)
				transmit_full <= 1'b0;
		end
	end
endmodule // tws_status
`default_nettype wire

/* File: bench/tws_status_checker.sv */
// port checker of the status-flag block
// assumes one clock and the one-cycle avalon answer
`timescale 1ns/1ps
`default_nettype none
module tws_status_checker #(parameter DATA_W = 8) (
	input wire logic clk_i, rst_n_i, clk_en_i, avs_read_i, avs_write_i, avs_waitrequest_o,
	input wire logic start_det_i, stop_det_i, addr_rcvd_i, addr_rw_i, byte_rcvd_i,
	input wire logic tx_done_i, busy_i, tx_load_o,
	input wire logic [3:0] avs_address_i, avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i, avs_readdata_o,
	input wire logic [DATA_W-1:0] rx_byte_i, tx_byte_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire rok = !avs_waitrequest_o && avs_read_i;
	// answer timing and transmit loads
	wait_pulse_a: assert property (!avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o)
		else $error("wait");
	answer_time_a: assert property ($rose(avs_read_i || avs_write_i) && clk_en_i
		|=> !avs_waitrequest_o) else $error("late");
	load_cause_a: assert property (tx_load_o |-> !avs_waitrequest_o && avs_write_i
		&& avs_address_i == 4'h8) else $error("load");
	load_data_a: assert property (tx_load_o |-> tx_byte_o == avs_writedata_i[7:0])
		else $error("byte");
	busy_drop_a: assert property (avs_write_i && busy_i && $past(busy_i) |-> !tx_load_o)
		else $error("busy");
	byte_hold_a: assert property (!tx_load_o |-> $stable(tx_byte_o)) else $error("hold");
	// read data of status and unmapped places
	status_zero_a: assert property (rok && avs_address_i == 4'h0
		|-> avs_readdata_o[31:8] == 0 && !avs_readdata_o[5]) else $error("stat");
	flag_excl_a: assert property (rok && avs_address_i == 4'h0
		|-> !(avs_readdata_o[3] && avs_readdata_o[4])) else $error("both");
	unmapped_zero_a: assert property (rok && avs_address_i != 4'h0
		&& avs_address_i != 4'h4 |-> avs_readdata_o == 0) else $error("unmap");
	cover property (tx_load_o);
	cover property (rok && avs_address_i == 4'h0 && avs_readdata_o[7]);
	cover property (rok && avs_address_i == 4'h4);
	cover property (avs_write_i && busy_i);
endmodule // tws_status_checker
bind tws_status tws_status_checker #(.DATA_W(DATA_W)) tws_status_checker_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.start_det_i(start_det_i), .stop_det_i(stop_det_i), .addr_rcvd_i(addr_rcvd_i),
	.addr_rw_i(addr_rw_i), .byte_rcvd_i(byte_rcvd_i), .tx_done_i(tx_done_i),
	.busy_i(busy_i), .tx_load_o(tx_load_o), .avs_address_i(avs_address_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .rx_byte_i(rx_byte_i), .tx_byte_o(tx_byte_o));
`default_nettype wire

/* File: bench/tws_bus_partner.sv */
// model of the bus sequencer feeding event pulses to the flag block
// assumes the bench gives one event code per cycle
`timescale 1ns/1ps
`default_nettype none
module tws_bus_partner (
	input  wire logic       clk_i,
	input  wire logic [2:0] ev_i,
	input  wire logic [7:0] d_i,
	output logic            st_o, sp_o, ad_o, by_o, td_o,
	output logic            rw_o = 1'b0,
	output logic [7:0]      rx_o = 8'hA5
);
	// one-cycle pulses; data lines scramble outside their valid cycle
	always @(posedge clk_i)
	begin
		st_o <= ev_i == 3'h1;
		sp_o <= ev_i == 3'h2;
		ad_o <= ev_i == 3'h3;
		by_o <= ev_i == 3'h4;
		td_o <= ev_i == 3'h5;
		rw_o <= (ev_i == 3'h3) ? d_i[0] : ~rw_o;
		rx_o <= (ev_i == 3'h4) ? d_i : ~rx_o;
	end
endmodule // tws_bus_partner
`default_nettype wire

/* File: bench/test_tws_status.sv */
// bench of the status-flag block: events, bytes and register access
// assumes design, partner and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_tws_status;
	logic clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, busy = 0, en = 1;
	logic st, sp, ad, rw, by, td, wq, ld;
	logic [2:0] ev = 0;
	logic [3:0] a = 0;
	logic [7:0] d = 0, b, rx, tb;
	logic [15:0] lf = 16'hD3AB;
	logic [31:0] wd = 0, rdat, q, s;
	int n_errors = 0, compares = 0, cyc = 0;
	tws_status tws_status_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en),
		.avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.start_det_i(st), .stop_det_i(sp), .addr_rcvd_i(ad), .addr_rw_i(rw),
		.byte_rcvd_i(by), .rx_byte_i(rx), .tx_done_i(td), .busy_i(busy),
		.tx_byte_o(tb), .tx_load_o(ld));
	tws_bus_partner tws_bus_partner_i (.clk_i(clk_i), .ev_i(ev), .d_i(d), .st_o(st),
		.sp_o(sp), .ad_o(ad), .by_o(by), .td_o(td), .rw_o(rw), .rx_o(rx));
	always #20 clk_i = ~clk_i;
	// cut a hang short
	always @(posedge clk_i) if (++cyc == 4000) begin n_errors++; report_and_stop; end
	function logic [7:0] rnd;
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	task chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin n_errors++; $display("[ERR] %0t exp %h got %h", $time, e, g); end
	endtask
	task bus(input logic w, input logic [3:0] ad_, input logic [31:0] v);
		rd <= !w; wr <= w; a <= ad_; wd <= v;
		do @(posedge clk_i); while (wq !== 1'b0);
		q = rdat; rd <= 0; wr <= 0;
		@(posedge clk_i);
	endtask
	task evt(input logic [2:0] c, input logic [7:0] v);
		ev <= c; d <= v;
		@(posedge clk_i);
		ev <= 0;
		repeat (2) @(posedge clk_i);
	endtask
	task stat(input logic [31:0] e); bus(0, 0, 0); chk(e, q); endtask
	task report_and_stop;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1;
		@(posedge clk_i);
		stat(0);
		evt(1, rnd()); stat(32'h08);
		evt(2, rnd()); stat(32'h10);
		for (int i = 0; i < 2; i++) begin evt(3, i[7:0]); stat(32'h10 | i << 2); end
		s = 32'h14; b = rnd();
		evt(4, b); stat(s | 2);
		evt(4, ~b); stat(s | 32'h42);
		bus(0, 4, 0); chk(b, q);
		bus(1, 0, 32'hFF); stat(s);
		b = rnd(); bus(1, 8, {24'h0, b}); chk(b, tb); stat(s | 1);
		evt(5, 0); stat(s);
		busy <= 1; bus(1, 8, 0); stat(s | 32'h80); chk(b, tb);
		busy <= 0; bus(0, 12, 0); chk(0, q);
		en <= 0; evt(1, 0); en <= 1; stat(s | 32'h80);
		report_and_stop;
	end
endmodule // test_tws_status
`default_nettype wire
